//--- counter_array_pkg.sv
// Purpose: Shared constants of the counter array and its capture modules
// Assumes: Byte-wide special function register access
// Notes: Module index n runs 0 to 2
package counter_array_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] CTRL_ADDR = 8'hd8;
  localparam logic [7:0] CFG_ADDR = 8'hd9;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'hf9;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'hfa;
  localparam logic [2:0][7:0] MODE_ADDR = {8'hdc, 8'hdb, 8'hda};
  localparam logic [2:0][7:0] CMP_LOW_ADDR = {8'heb, 8'he9, 8'hfb};
  localparam logic [2:0][7:0] CMP_HIGH_ADDR = {8'hec, 8'hea, 8'hfc};
  localparam int NUM_MODULES = 3;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int MODE_WIDE_BIT = 7;
  localparam int MODE_CMP_BIT = 6;
  localparam int MODE_RISE_BIT = 5;
  localparam int MODE_FALL_BIT = 4;
  localparam int MODE_MATCH_BIT = 3;
  localparam int MODE_TOG_BIT = 2;
  localparam int MODE_PWM_BIT = 1;
  localparam int MODE_IRQ_BIT = 0;
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int CFG_TB_LSB = 1;
  localparam int CFG_OVF_IRQ_BIT = 0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // ****************************************
  // Timebase codes and dividers
  // ****************************************
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4 = 3'h1;
  localparam logic [2:0] TB_TIMER0 = 3'h2;
  localparam logic [2:0] TB_EXT_FALL = 3'h3;
  localparam logic [2:0] TB_SYSCLK = 3'h4;
  localparam logic [2:0] TB_EXTCLK8 = 3'h5;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
endpackage

//--- capture_compare_module.sv
// Purpose: One capture/compare module of the counter array
// Assumes: Pin and counter are synchronous to sys_clk_in
// Notes: Match is judged only in the cycle after the counter advances
`timescale 1ns/1ps
module capture_compare_module (
  input wire logic sys_clk_in, // System clock
  input wire logic rstn_in, // Synchronous reset, active low
  input wire logic [7:0] mode_in, // Mode byte
  input wire logic [15:0] count_in, // Shared counter
  input wire logic count_new_in, // Counter advanced last cycle
  input wire logic pin_in, // Module pin level
  input wire logic wr_low_in, // Write strobe, low byte
  input wire logic wr_high_in, // Write strobe, high byte
  input wire logic [7:0] wdata_in, // Write data
  output logic [15:0] value_out, // Capture/compare value
  output logic event_out, // Flag set pulse
  output logic pin_out, // Pin drive level
  output logic pin_oe_n_out // Pin drive enable, active low
);
  typedef struct packed {
    logic [15:0] value;
    logic pin;
    logic pin_prev;
  } cc_state_t;

  cc_state_t st_r;
  cc_state_t st_nxt;
  logic cap_hit;
  logic match;
  logic low_ovf;
  logic full_ovf;
  logic pwm_on;
  logic tog_on;

  // Edge, match and overflow detection
  always_comb
  begin
    pwm_on = mode_in[counter_array_pkg::MODE_PWM_BIT];
    tog_on = mode_in[counter_array_pkg::MODE_TOG_BIT];
    cap_hit = (pin_in & ~st_r.pin_prev & mode_in[counter_array_pkg::MODE_RISE_BIT])
      | (~pin_in & st_r.pin_prev & mode_in[counter_array_pkg::MODE_FALL_BIT]);
    low_ovf = count_new_in && (count_in[7:0] == counter_array_pkg::BYTE_RESET);
    full_ovf = low_ovf && (count_in[15:8] == counter_array_pkg::BYTE_RESET);
    if (pwm_on && !tog_on && !mode_in[counter_array_pkg::MODE_WIDE_BIT])
    begin
      match = count_in[7:0] == st_r.value[7:0];
    end
    else
    begin
      match = count_in == st_r.value;
    end
    match = match && count_new_in && mode_in[counter_array_pkg::MODE_CMP_BIT];
  end

  // Next state of value and pin
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pin_prev = pin_in;
    if (wr_low_in)
    begin
      st_nxt.value[7:0] = wdata_in;
    end
    if (wr_high_in)
    begin
      st_nxt.value[15:8] = wdata_in;
    end
    if (cap_hit)
    begin
      st_nxt.value = count_in;
    end
    case ({pwm_on, tog_on})
      2'h3:
      begin
        // Frequency output: toggle and step the next match point
        if (match)
        begin
          st_nxt.pin = ~st_r.pin;
          st_nxt.value[7:0] = st_r.value[7:0] + st_r.value[15:8];
        end
      end
      2'h2:
      begin
        // Pulse width: high from match until overflow
        if (mode_in[counter_array_pkg::MODE_WIDE_BIT])
        begin
          if (full_ovf)
          begin
            st_nxt.pin = 1'b0;
          end
        end
        else if (low_ovf)
        begin
          st_nxt.pin = 1'b0;
          st_nxt.value[7:0] = st_r.value[15:8];
        end
        if (match)
        begin
          st_nxt.pin = 1'b1;
        end
      end
      2'h1:
      begin
        if (match)
        begin
          st_nxt.pin = ~st_r.pin;
        end
      end
      default:
      begin
        st_nxt.pin = st_r.pin;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign value_out = st_r.value;
  assign event_out = cap_hit | (match & mode_in[counter_array_pkg::MODE_MATCH_BIT]);
  assign pin_out = st_r.pin;
  assign pin_oe_n_out = ~(pwm_on | tog_on);

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  a_capture_copy: assert property (cap_hit && !wr_low_in && !wr_high_in |=> value_out == $past(count_in))
    else $error("capture did not copy counter");
  a_toggle_pin: assert property (match && tog_on && !pwm_on |=> pin_out != $past(pin_out))
    else $error("toggle missed on match");
  a_cmp_off: assert property (!mode_in[counter_array_pkg::MODE_CMP_BIT] && !cap_hit |-> !event_out)
    else $error("event with comparator disabled");
  c_capture: cover property (cap_hit);
  c_freq_out: cover property (match && pwm_on && tog_on);
endmodule

//--- counter_array_capture_compare.sv
// Purpose: Counter array with shared counter and three capture modules
// Assumes: Byte register port synchronous to sys_clk_in, inputs synchronous
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/1ps

// Notes on behaviour
// - Width-select bit picks 8-bit or 16-bit pulse width generation.
// - Comparator works only while its enable bit is set.
// - Rising pin edges capture only while rising enable is set.
// - Falling pin edges capture only while falling enable is set.
// - With match enabled, counter equal to module value sets the flag.
// - With toggle enabled, each match inverts the module pin.
// - Toggle plus pulse width gives frequency output mode.
// - Pulse width enable drives a modulated waveform on the pin.
// - Flag plus its interrupt enable raises the request; else masked.
// - Counter is read and written as low and high bytes.
// - Each module value is reached as low and high bytes.
// - Three identical modules with their own addresses.
// - Module flag set by match or capture, cleared only by software.
// - Overflow flag set on wrap from all ones, cleared by software.
// - Counter advances only while run bit is one.
// - Timebase field selects one of six count sources.
module counter_array_capture_compare (
  input wire logic sys_clk_in, // System clock, 250 MHz
  input wire logic rstn_in, // Synchronous reset, active low
  input wire logic [7:0] sfr_addr_in, // Register address
  input wire logic sfr_wr_in, // Write strobe
  input wire logic [7:0] sfr_wdata_in, // Write data
  input wire logic sfr_rd_in, // Read strobe
  output logic [7:0] sfr_rdata_out, // Read data, one cycle later
  input wire logic timer0_ovf_in, // Timer 0 overflow pulse
  input wire logic external_count_input_in, // Count pin, falling edges
  input wire logic ext_clock_in, // External clock level
  input wire logic [2:0] module_io_pin_in, // Module pin levels
  output logic [2:0] module_io_pin_out, // Module pin drive
  output logic [2:0] module_io_pin_oe_n_out, // Module pin enable, active low
  output logic irq_req_out // Interrupt request
);
  typedef struct packed {
    logic [15:0] count;
    logic run;
    logic ovf_flag;
    logic [2:0] mod_flag;
    logic [2:0] tb_sel;
    logic ovf_irq_en;
    logic [2:0][7:0] mode;
    logic [3:0] div12;
    logic [1:0] div4;
    logic [2:0] div8;
    logic count_pin_prev;
    logic ext_prev;
    logic tick_d;
    logic [7:0] rdata;
  } top_state_t;

  top_state_t st_r;
  top_state_t st_nxt;
  logic tb_tick;
  logic tick;
  logic ext_rise;
  logic wr_ctrl;
  logic [2:0] events;
  logic [2:0] wr_low;
  logic [2:0] wr_high;
  logic [2:0][15:0] values;

  // ****************************************
  // Capture/compare modules
  // ****************************************
  // Write strobes per module
  always_comb
  begin
    for (int i = 0; i < counter_array_pkg::NUM_MODULES; i++)
    begin
      wr_low[i] = sfr_wr_in && (sfr_addr_in == counter_array_pkg::CMP_LOW_ADDR[i]);
      wr_high[i] = sfr_wr_in && (sfr_addr_in == counter_array_pkg::CMP_HIGH_ADDR[i]);
    end
  end

  // Three identical modules
  generate
    for (genvar g = 0; g < counter_array_pkg::NUM_MODULES; g++)
    begin : g_mod
      capture_compare_module u_mod (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .mode_in(st_r.mode[g]),
        .count_in(st_r.count),
        .count_new_in(st_r.tick_d),
        .pin_in(module_io_pin_in[g]),
        .wr_low_in(wr_low[g]),
        .wr_high_in(wr_high[g]),
        .wdata_in(sfr_wdata_in),
        .value_out(values[g]),
        .event_out(events[g]),
        .pin_out(module_io_pin_out[g]),
        .pin_oe_n_out(module_io_pin_oe_n_out[g])
      );
    end
  endgenerate

  // ****************************************
  // Timebase selection
  // ****************************************
  // Count source for the shared counter
  always_comb
  begin
    ext_rise = ext_clock_in & ~st_r.ext_prev;
    case (st_r.tb_sel)
      counter_array_pkg::TB_DIV12: tb_tick = st_r.div12 == counter_array_pkg::DIV12_LAST;
      counter_array_pkg::TB_DIV4: tb_tick = st_r.div4 == counter_array_pkg::DIV4_LAST;
      counter_array_pkg::TB_TIMER0: tb_tick = timer0_ovf_in;
      counter_array_pkg::TB_EXT_FALL: tb_tick = st_r.count_pin_prev & ~external_count_input_in;
      counter_array_pkg::TB_SYSCLK: tb_tick = 1'b1;
      counter_array_pkg::TB_EXTCLK8: tb_tick = ext_rise && (st_r.div8 == counter_array_pkg::DIV8_LAST);
      default: tb_tick = 1'b0;
    endcase
    tick = tb_tick && st_r.run;
  end

  // ****************************************
  // Register file and counter
  // ****************************************
  assign wr_ctrl = sfr_wr_in && (sfr_addr_in == counter_array_pkg::CTRL_ADDR);

  // Next state of counter, flags, dividers and registers
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.count_pin_prev = external_count_input_in;
    st_nxt.ext_prev = ext_clock_in;
    st_nxt.tick_d = tick;
    st_nxt.div12 = (st_r.div12 == counter_array_pkg::DIV12_LAST) ? '0 : st_r.div12 + 4'h1;
    st_nxt.div4 = st_r.div4 + 2'h1;
    if (ext_rise)
    begin
      st_nxt.div8 = st_r.div8 + 3'h1;
    end
    if (tick)
    begin
      st_nxt.count = st_r.count + counter_array_pkg::COUNT_ONE;
    end
    if (sfr_wr_in)
    begin
      for (int i = 0; i < counter_array_pkg::NUM_MODULES; i++)
      begin
        if (sfr_addr_in == counter_array_pkg::MODE_ADDR[i])
        begin
          st_nxt.mode[i] = sfr_wdata_in;
        end
      end
      case (sfr_addr_in)
        counter_array_pkg::CTRL_ADDR:
        begin
          st_nxt.run = sfr_wdata_in[counter_array_pkg::CTRL_RUN_BIT];
          st_nxt.ovf_flag = sfr_wdata_in[counter_array_pkg::CTRL_OVF_BIT];
          st_nxt.mod_flag = sfr_wdata_in[2:0];
        end
        counter_array_pkg::CFG_ADDR:
        begin
          st_nxt.tb_sel = sfr_wdata_in[counter_array_pkg::CFG_TB_LSB +: 3];
          st_nxt.ovf_irq_en = sfr_wdata_in[counter_array_pkg::CFG_OVF_IRQ_BIT];
        end
        counter_array_pkg::COUNT_LOW_ADDR: st_nxt.count[7:0] = sfr_wdata_in;
        counter_array_pkg::COUNT_HIGH_ADDR: st_nxt.count[15:8] = sfr_wdata_in;
        default: st_nxt.run = st_nxt.run;
      endcase
    end
    // Hardware set wins over a software clear in the same cycle
    if (tick && (st_r.count == counter_array_pkg::COUNT_MAX))
    begin
      st_nxt.ovf_flag = 1'b1;
    end
    st_nxt.mod_flag = st_nxt.mod_flag | events;
    st_nxt.rdata = counter_array_pkg::BYTE_RESET;
    if (sfr_rd_in)
    begin
      case (sfr_addr_in)
        counter_array_pkg::CTRL_ADDR:
          st_nxt.rdata = {st_r.ovf_flag, st_r.run, 3'h0, st_r.mod_flag};
        counter_array_pkg::CFG_ADDR:
          st_nxt.rdata = {4'h0, st_r.tb_sel, st_r.ovf_irq_en};
        counter_array_pkg::COUNT_LOW_ADDR: st_nxt.rdata = st_r.count[7:0];
        counter_array_pkg::COUNT_HIGH_ADDR: st_nxt.rdata = st_r.count[15:8];
        default:
        begin
          for (int i = 0; i < counter_array_pkg::NUM_MODULES; i++)
          begin
            if (sfr_addr_in == counter_array_pkg::MODE_ADDR[i])
            begin
              st_nxt.rdata = st_r.mode[i];
            end
            if (sfr_addr_in == counter_array_pkg::CMP_LOW_ADDR[i])
            begin
              st_nxt.rdata = values[i][7:0];
            end
            if (sfr_addr_in == counter_array_pkg::CMP_HIGH_ADDR[i])
            begin
              st_nxt.rdata = values[i][15:8];
            end
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Request from enabled flags
  always_comb
  begin
    irq_req_out = st_r.ovf_flag & st_r.ovf_irq_en;
    for (int i = 0; i < counter_array_pkg::NUM_MODULES; i++)
    begin
      irq_req_out = irq_req_out
        | (st_r.mod_flag[i] & st_r.mode[i][counter_array_pkg::MODE_IRQ_BIT]);
    end
  end

  assign sfr_rdata_out = st_r.rdata;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  a_run_hold: assert property (!st_r.run && !sfr_wr_in |=> $stable(st_r.count))
    else $error("counter moved while stopped");
  a_ovf_set: assert property (tick && st_r.count == 16'hffff |=> st_r.ovf_flag && st_r.count == 16'h0000)
    else $error("overflow flag not set on wrap");
  a_flag_sticky: assert property (st_r.mod_flag[0] && !wr_ctrl |=> st_r.mod_flag[0])
    else $error("module flag cleared without write");
  a_flag_set: assert property (events[1] |=> st_r.mod_flag[1])
    else $error("module flag not set on event");
  a_irq_mask: assert property (st_r.mod_flag[2] && st_r.mode[2][0] |-> irq_req_out)
    else $error("request missing for enabled flag");
  // A timebase change right after a tick may legally bring a faster tick
  a_div12_gap: assert property (st_r.tb_sel == counter_array_pkg::TB_DIV12 && tb_tick
    |=> (!tb_tick || st_r.tb_sel != counter_array_pkg::TB_DIV12) [*8])
    else $error("divide by twelve ticks too close");
  // Reset itself is the antecedent, so the default disable must not apply
  a_reset_zero: assert property (disable iff (1'b0) !rstn_in
    |=> st_r.count == 16'h0000 && st_r.mode == '0 && !irq_req_out)
    else $error("state not cleared by reset");
  c_overflow: cover property (tick && st_r.count == 16'hffff);
  c_irq: cover property (irq_req_out);
endmodule

//--- pin_partner.sv
// Purpose: Outside circuit on the three module pins
// Assumes: The bench sets the level the outside circuit drives
// Notes: The wire follows the module whenever the module drives it
`timescale 1ns/1ps
module pin_partner (
  input wire logic [2:0] level_in, // Level driven from outside
  input wire logic [2:0] drive_in, // Module drive level
  input wire logic [2:0] oe_n_in, // Module drive enable, active low
  output logic [2:0] pin_out // Resolved pin level
);
  // Module wins while it drives, else the outside level
  always_comb
  begin
    for (int n = 0; n < 3; n++)
    begin
      pin_out[n] = oe_n_in[n] ? level_in[n] : drive_in[n];
    end
  end
endmodule

//--- test_counter_array_capture_compare.sv
// Purpose: Self-checking bench for the counter array
// Assumes: Register port answers one cycle after a read strobe
// Notes: Counting windows allow a cycle or two of start and stop slack
`timescale 1ns/1ps
module test_counter_array_capture_compare;
  localparam logic [7:0] ctrl_a = counter_array_pkg::CTRL_ADDR;
  localparam logic [7:0] cfg_a = counter_array_pkg::CFG_ADDR;
  localparam logic [7:0] cnt_lo = counter_array_pkg::COUNT_LOW_ADDR;
  localparam logic [7:0] cnt_hi = counter_array_pkg::COUNT_HIGH_ADDR;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic timer0 = 1'b0;
  logic ecnt = 1'b0;
  logic eclk = 1'b0;
  logic [2:0] lvl = 3'h0;
  logic [7:0] rdata;
  logic [2:0] pin_in;
  logic [2:0] pin_out;
  logic [2:0] oe_n;
  logic irq;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  int hi_cnt;
  int tg_cnt;

  // Design and the outside pin circuit
  counter_array_capture_compare dut (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .sfr_addr_in(addr),
    .sfr_wr_in(wr_s), .sfr_wdata_in(wdata), .sfr_rd_in(rd_s),
    .sfr_rdata_out(rdata), .timer0_ovf_in(timer0),
    .external_count_input_in(ecnt), .ext_clock_in(eclk),
    .module_io_pin_in(pin_in), .module_io_pin_out(pin_out),
    .module_io_pin_oe_n_out(oe_n), .irq_req_out(irq));
  pin_partner partner (.level_in(lvl), .drive_in(pin_out), .oe_n_in(oe_n), .pin_out(pin_in));

  // Clock of 4 ns and hang guard
  initial
  begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp,
                     input int tol);
    int d;
    begin
      d = int'(seen) - int'(exp);
      cmp_count++;
      if ($isunknown(seen) || d > tol || d < -tol)
      begin
        mismatches++;
        $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    begin
      @(posedge sys_clk_in);
      #1;
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      @(posedge sys_clk_in);
      #1;
      wr_s = 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    begin
      @(posedge sys_clk_in);
      #1;
      addr = a;
      rd_s = 1'b1;
      @(posedge sys_clk_in);
      #1;
      rd_s = 1'b0;
      d = rdata;
    end
  endtask
  task automatic rd16(input logic [7:0] la, input logic [7:0] ha, output logic [15:0] v);
    logic [7:0] l;
    logic [7:0] h;
    begin
      rd(la, l);
      rd(ha, h);
      v = {h, l};
    end
  endtask
  // Preset and run the counter for n cycles with stimulus, then stop it keeping flags
  task automatic tb_run(input logic [2:0] code, input int n, input logic [15:0] start);
    logic [7:0] c;
    logic last;
    begin
      wr(ctrl_a, 8'h00);
      wr(cnt_lo, start[7:0]);
      wr(cnt_hi, start[15:8]);
      wr(cfg_a, {4'h0, code, 1'b0});
      hi_cnt = 0;
      tg_cnt = 0;
      last = pin_out[1];
      wr(ctrl_a, 8'h40);
      for (int i = 0; i < n; i++)
      begin
        @(posedge sys_clk_in);
        #1;
        timer0 = (i % 8 == 0);
        ecnt = ((i / 4) % 2 == 1);
        eclk = ((i / 2) % 2 == 1);
        hi_cnt += int'(pin_out[0]);
        tg_cnt += int'(pin_out[1] != last);
        last = pin_out[1];
      end
      timer0 = 1'b0;
      rd(ctrl_a, c);
      wr(ctrl_a, c & 8'hbf);
    end
  endtask
  task automatic give_verdict();
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
      begin
        $display("Test passed");
      end
      else
      begin
        $display("Test failed");
      end
      $finish;
    end
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    logic [7:0] b;
    logic [15:0] v;
    logic [15:0] w;
    int tb_exp [8] = '{8, 24, 12, 11, 99, 3, 0, 0};
    int tb_tol [8] = '{1, 1, 1, 1, 2, 1, 0, 0};
    logic [7:0] cap_mode [4] = '{8'h21, 8'h21, 8'h11, 8'h11};
    logic [15:0] cap_cnt [4] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0};
    logic [15:0] cap_exp [4] = '{16'h1234, 16'h1234, 16'h1234, 16'hdef0};
    repeat (10) @(posedge sys_clk_in);
    #1;
    rstn_in = 1'b1;
    chk("pin enables", {13'h0, oe_n}, 16'h0007, 0);
    // Reset values, then distinct values per module read back
    for (int n = 0; n < 3; n++)
    begin
      rd(counter_array_pkg::MODE_ADDR[n], b);
      chk("mode", {8'h00, b}, 16'h0000, 0);
      rd16(counter_array_pkg::CMP_LOW_ADDR[n], counter_array_pkg::CMP_HIGH_ADDR[n], v);
      chk("value", v, 16'h0000, 0);
      wr(counter_array_pkg::MODE_ADDR[n], 8'h80 + 8'(n));
      wr(counter_array_pkg::CMP_LOW_ADDR[n], 8'ha0 + 8'(n));
      wr(counter_array_pkg::CMP_HIGH_ADDR[n], 8'hb0 + 8'(n));
    end
    rd16(cnt_lo, cnt_hi, v);
    chk("count", v, 16'h0000, 0);
    for (int n = 0; n < 3; n++)
    begin
      rd(counter_array_pkg::MODE_ADDR[n], b);
      chk("mode", {8'h00, b}, 16'h0080 + 16'(n), 0);
      rd16(counter_array_pkg::CMP_LOW_ADDR[n], counter_array_pkg::CMP_HIGH_ADDR[n], v);
      chk("value", v, {8'hb0 + 8'(n), 8'ha0 + 8'(n)}, 0);
      wr(counter_array_pkg::MODE_ADDR[n], 8'h00);
      wr(counter_array_pkg::CMP_HIGH_ADDR[n], 8'h00);
    end
    wr(8'h80, 8'hff);
    rd(8'h80, b);
    chk("unmapped", {8'h00, b}, 16'h0000, 0);
    // Every timebase code over the same stimulus
    for (int k = 0; k < 8; k++)
    begin
      tb_run(3'(k), 96, 16'h0000);
      rd16(cnt_lo, cnt_hi, v);
      chk("timebase count", v, 16'(tb_exp[k]), tb_tol[k]);
    end
    // Wrap sets overflow, stopped counter holds, overflow request and clear
    tb_run(3'h4, 40, 16'hfff0);
    rd(ctrl_a, b);
    chk("overflow", {15'h0, b[7]}, 16'h0001, 0);
    rd16(cnt_lo, cnt_hi, v);
    chk("wrapped count", v, 16'h001b, 3);
    repeat (20) @(posedge sys_clk_in);
    rd16(cnt_lo, cnt_hi, w);
    chk("held count", w, v, 0);
    wr(cfg_a, 8'h09);
    chk("overflow irq", {15'h0, irq}, 16'h0001, 0);
    wr(ctrl_a, 8'h00);
    rd(ctrl_a, b);
    chk("control", {8'h00, b}, 16'h0000, 0);
    chk("irq", {15'h0, irq}, 16'h0000, 0);
    // Match flag, its mask, and comparator gating
    wr(counter_array_pkg::CMP_LOW_ADDR[0], 8'h10);
    wr(counter_array_pkg::MODE_ADDR[0], 8'h49);
    tb_run(3'h4, 40, 16'h0000);
    rd(ctrl_a, b);
    chk("flag0", {15'h0, b[0]}, 16'h0001, 0);
    chk("irq", {15'h0, irq}, 16'h0001, 0);
    wr(counter_array_pkg::MODE_ADDR[0], 8'h48);
    chk("masked irq", {15'h0, irq}, 16'h0000, 0);
    rd(ctrl_a, b);
    chk("flag0 kept", {15'h0, b[0]}, 16'h0001, 0);
    wr(counter_array_pkg::MODE_ADDR[0], 8'h08);
    tb_run(3'h4, 40, 16'h0000);
    rd(ctrl_a, b);
    chk("flag0 off", {15'h0, b[0]}, 16'h0000, 0);
    // Toggle on match, then frequency output
    wr(counter_array_pkg::CMP_LOW_ADDR[1], 8'h20);
    wr(counter_array_pkg::MODE_ADDR[1], 8'h44);
    chk("pin1 enable", {15'h0, oe_n[1]}, 16'h0000, 0);
    tb_run(3'h4, 60, 16'h0000);
    chk("pin1", {15'h0, pin_out[1]}, 16'h0001, 0);
    rd(ctrl_a, b);
    chk("flag1", {15'h0, b[1]}, 16'h0000, 0);
    wr(counter_array_pkg::CMP_LOW_ADDR[1], 8'h10);
    wr(counter_array_pkg::CMP_HIGH_ADDR[1], 8'h20);
    wr(counter_array_pkg::MODE_ADDR[1], 8'h46);
    tb_run(3'h4, 200, 16'h2000);
    chk("toggles", 16'(tg_cnt), 16'h0006, 1);
    wr(counter_array_pkg::MODE_ADDR[1], 8'h00);
    // Pulse width, 8-bit then 16-bit, counting high cycles
    for (int k = 0; k < 2; k++)
    begin
      w = (k == 0) ? 16'hc0c0 : 16'hffc0;
      wr(counter_array_pkg::CMP_LOW_ADDR[0], w[7:0]);
      wr(counter_array_pkg::CMP_HIGH_ADDR[0], w[15:8]);
      wr(counter_array_pkg::MODE_ADDR[0], (k == 0) ? 8'h42 : 8'hc2);
      chk("pin0 enable", {15'h0, oe_n[0]}, 16'h0000, 0);
      tb_run(3'h4, 600, 16'hff00);
      chk("high cycles", 16'(hi_cnt), (k == 0) ? 16'd128 : 16'd64, 4);
    end
    wr(counter_array_pkg::MODE_ADDR[0], 8'h00);
    // Captures on rising and falling pin edges as enabled
    for (int k = 0; k < 4; k++)
    begin
      wr(ctrl_a, 8'h00);
      wr(counter_array_pkg::MODE_ADDR[2], cap_mode[k]);
      wr(cnt_lo, cap_cnt[k][7:0]);
      wr(cnt_hi, cap_cnt[k][15:8]);
      @(posedge sys_clk_in);
      #1;
      lvl[2] = ~lvl[2];
      repeat (4) @(posedge sys_clk_in);
      rd16(counter_array_pkg::CMP_LOW_ADDR[2], counter_array_pkg::CMP_HIGH_ADDR[2], v);
      chk("captured", v, cap_exp[k], 0);
      rd(ctrl_a, b);
      chk("flag2", {15'h0, b[2]}, (k == 0 || k == 3) ? 16'h0001 : 16'h0000, 0);
      chk("irq2", {15'h0, irq}, (k == 0 || k == 3) ? 16'h0001 : 16'h0000, 0);
    end
    give_verdict();
  end
endmodule
